// [design/usbep_pkg.sv]
// Purpose: Shared constants and types for the USB endpoint control block
// Assumes: Wishbone classic, 32-bit data, byte address = 4 x register index
// Notes:   Register indices are kept as printed; bus decodes adr[31:2]
package usbep_pkg;

   // ************************************************************
   // Register indices
   // ************************************************************
   localparam logic [31:0] RXCTL_IDX  = 32'h5000186e;
   localparam logic [31:0] EPCFG_IDX  = 32'h50001870;
   localparam logic [31:0] TXDATA_IDX = 32'h50001872;
   localparam logic [31:0] EVENT_IDX  = 32'h50001878;
   localparam logic [31:0] MODE_IDX   = 32'h5000187a;
   localparam logic [31:0] RXDATA_IDX = 32'h5000187c;

   // ************************************************************
   // Field positions and reset values
   // ************************************************************
   localparam int RXC_EN_BIT    = 0;
   localparam int RXC_IGN_BIT   = 2;
   localparam int RXC_FLUSH_BIT = 3;
   localparam int RXC_WL_LSB    = 5;
   localparam int EPC_EN_BIT    = 4;
   localparam int EPC_ISO_BIT   = 5;
   localparam int EPC_STALL_BIT = 7;
   localparam int MODE_TXEN_BIT = 0;
   localparam int MODE_TEST_BIT = 1;
   localparam int EV_WARN_BIT   = 0;
   localparam logic [7:0] RXC_RST  = 8'h00;
   localparam logic [7:0] EPC_RST  = 8'h00;
   localparam logic [7:0] MODE_RST = 8'h00;

   // ************************************************************
   // Warning limits, FIFO sizes, bus timing
   // ************************************************************
   localparam logic [6:0] WL_LIM1  = 7'h05;
   localparam logic [6:0] WL_LIM2  = 7'h09;
   localparam logic [6:0] WL_LIM3  = 7'h11;
   localparam int         TX_DEPTH = 16;
   localparam int         RX_DEPTH = 64;
   localparam int         DATA_W   = 8;
   localparam int         ACK_LAT  = 1;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {PID_OUT, PID_IN, PID_SETUP} usbep_pid_e;
   typedef enum logic [1:0] {HS_ACK, HS_NAK, HS_STALL, HS_DATA} usbep_hs_e;
   typedef enum logic [1:0] {RX_IDLE, RX_STORE, RX_DROP} usbep_rx_e;

   typedef struct packed {
      usbep_pid_e pid;
      logic [6:0] addr;
      logic [3:0] ep;
   } usbep_tok_s;

endpackage : usbep_pkg

// [design/usbep_fifo.sv]
// Purpose: Synchronous FIFO with valid/ready on both sides and flush
// Assumes: DEPTH is a power of two
// Notes:   Read data is the head word, valid while out_valid_o is high
`timescale 1ns/1ns
module usbep_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 16
) (
   input  wire logic                       mclk_i,       // System clock
   input  wire logic                       rst_n_i,      // Async reset, active low
   input  wire logic                       flush_i,      // Drop all contents
   input  wire logic                       in_valid_i,   // Write request
   output logic                            in_ready_o,   // Not full
   input  wire logic [W-1:0]               in_data_i,    // Write data
   output logic                            out_valid_o,  // Not empty
   input  wire logic                       out_ready_i,  // Pop request
   output logic [W-1:0]                    out_data_o,   // Head word
   output logic [$clog2(DEPTH):0]          count_o       // Words held
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wr_ptr_reg;
   logic [AW:0]  rd_ptr_reg;
   logic         push;
   logic         pop;

   assign count_o     = wr_ptr_reg - rd_ptr_reg;
   assign in_ready_o  = count_o != (AW+1)'(DEPTH);
   assign out_valid_o = count_o != '0;
   assign out_data_o  = mem[rd_ptr_reg[AW-1:0]];
   assign push        = in_valid_i && in_ready_o && !flush_i;
   assign pop         = out_valid_o && out_ready_i && !flush_i;

   always_ff @(posedge mclk_i) begin
      if (push) begin
         mem[wr_ptr_reg[AW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else if (flush_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end

endmodule : usbep_fifo

// [design/usbep_ctrl.sv]
// Purpose: Endpoint FIFO control: receive control, endpoint config, transmit port
// Assumes: Token, byte and packet-end strobes come from logic on mclk_i
// Notes:   Registers over Wishbone classic; one-cycle ack
//
// Overview of operation
// RULE_01: Warning-limit code 00 off, 01 below 5, 10 below 9, 11 below 17 free.
// RULE_02: Free receive bytes under the selected limit set the warning event flag.
// RULE_03: Writing flush discards receive data, idles endpoint, resets both pointers.
// RULE_04: Flush waits while a packet is being received into the FIFO.
// RULE_05: Setup-mask bit makes the endpoint ignore SETUP tokens to its address.
// RULE_06: Reception disarms after each OUT packet or OUT stall; software re-arms.
// RULE_07: SETUP packets are taken whether reception is armed or not.
// RULE_08: Repeated SETUP with no other token between is dropped but acknowledged.
// RULE_09: A SETUP that cannot be taken otherwise gets no handshake.
// RULE_10: Stall answers IN when transmit enabled, OUT when receive armed.
// RULE_11: Stall never answers a SETUP token.
// RULE_12: Isochronous endpoint sends no NAK when not ready.
// RULE_13: Enabled endpoint matches number and device address; disabled ignores tokens.
// RULE_14: Config register holds a read/write four-bit endpoint number.
// RULE_15: Software writes only payload bytes; framing is added downstream.
// RULE_16: Test mode allows the bus to read the transmit data port too.
// RULE_17: Software flushes the receive FIFO after a media error.
// RULE_18: Reserved bits read zero and ignore writes.
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ns
module usbep_ctrl
   import usbep_pkg::*;
(
   input  wire logic                   mclk_i,       // 20 MHz system clock
   input  wire logic                   rst_n_i,      // Async reset, active low
   input  wire logic                   wb_cyc_i,     // Bus cycle
   input  wire logic                   wb_stb_i,     // Bus strobe
   input  wire logic                   wb_we_i,      // Write enable
   input  wire logic [31:0]            wb_adr_i,     // Byte address
   input  wire logic [3:0]             wb_sel_i,     // Byte enables
   input  wire logic [31:0]            wb_dat_i,     // Write data
   output logic      [31:0]            wb_dat_o,     // Read data
   output logic                        wb_ack_o,     // Acknowledge
   input  wire logic [6:0]             func_addr_i,  // Device address
   input  wire logic                   tok_valid_i,  // Token strobe
   input  wire usbep_pkg::usbep_tok_s  tok_i,        // Token contents
   input  wire logic                   rx_valid_i,   // Received payload byte strobe
   input  wire logic [7:0]             rx_byte_i,    // Received payload byte
   input  wire logic                   rx_end_i,     // Good packet end strobe
   output logic                        hs_valid_o,   // Handshake request pulse
   output usbep_pkg::usbep_hs_e        hs_kind_o,    // Handshake kind
   input  wire logic                   tx_req_i,     // Engine wants next byte
   output logic                        tx_valid_o,   // Transmit byte valid pulse
   output logic      [7:0]             tx_byte_o,    // Transmit byte
   output logic                        rx_busy_o     // Packet reception active
);

   // ************************************************************
   // Declarations
   // ************************************************************
   logic [7:0]  rxc_reg, epc_reg, mode_reg;
   logic        flush_pend_reg, warn_ev_reg, setup_held_reg, end_send_reg, end_setup_reg;
   usbep_hs_e   end_kind_reg;
   usbep_rx_e   rx_state_reg;
   logic        bus_req, bus_go, wr_lo;
   logic        hit_rxc, hit_epc, hit_txd, hit_ev, hit_mode, hit_rxd;
   logic        tx_in_valid, tx_in_ready, tx_out_valid, tx_pop;
   logic [7:0]  tx_head;
   logic        rx_in_valid, rx_in_ready, rx_out_valid, rx_pop;
   logic [7:0]  rx_head;
   logic [6:0]  rx_count, rx_free, warn_lim;
   logic        warn_hit, rx_flush, tok_match, rx_armed, iso, stall;

   function automatic logic hit(input logic [31:0] adr, input logic [31:0] idx);
      hit = adr[31:2] == idx[29:0];
   endfunction : hit

   // ************************************************************
   // Wishbone slave
   // ************************************************************
   assign bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign hit_rxc  = hit(wb_adr_i, RXCTL_IDX);
   assign hit_epc  = hit(wb_adr_i, EPCFG_IDX);
   assign hit_txd  = hit(wb_adr_i, TXDATA_IDX);
   assign hit_ev   = hit(wb_adr_i, EVENT_IDX);
   assign hit_mode = hit(wb_adr_i, MODE_IDX);
   assign hit_rxd  = hit(wb_adr_i, RXDATA_IDX);
   // Transmit writes stall while the FIFO is full
   assign bus_go   = bus_req && !(hit_txd && wb_we_i && !tx_in_ready);
   assign wr_lo    = bus_go && wb_we_i && wb_sel_i[0];

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_go;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wb_dat_o <= '0;
      end else if (bus_go && !wb_we_i) begin
         wb_dat_o <= '0; // [RULE_18]
         if (hit_rxc) begin
            wb_dat_o[7:0] <= {1'b0, rxc_reg[6:5], 1'b0, flush_pend_reg, rxc_reg[2], 1'b0,
                              rxc_reg[0]};
         end else if (hit_epc) begin
            wb_dat_o[7:0] <= {epc_reg[7], 1'b0, epc_reg[5:0]}; // [RULE_14]
         end else if (hit_txd && mode_reg[MODE_TEST_BIT]) begin
            wb_dat_o[7:0] <= tx_head; // [RULE_16]
         end else if (hit_ev) begin
            wb_dat_o[0] <= warn_ev_reg;
         end else if (hit_mode) begin
            wb_dat_o[7:0] <= {6'h00, mode_reg[1:0]};
         end else if (hit_rxd) begin
            wb_dat_o[7:0] <= rx_head;
         end
      end
   end

   // ************************************************************
   // Configuration registers
   // ************************************************************
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         epc_reg  <= EPC_RST;
         mode_reg <= MODE_RST;
      end else begin
         if (wr_lo && hit_epc) begin
            epc_reg <= wb_dat_i[7:0] & 8'hbf; // [RULE_14] [RULE_18]
         end
         if (wr_lo && hit_mode) begin
            mode_reg <= wb_dat_i[7:0] & 8'h03;
         end
      end
   end

   assign iso      = epc_reg[EPC_ISO_BIT];
   assign stall    = epc_reg[EPC_STALL_BIT];
   assign rx_armed = rxc_reg[RXC_EN_BIT];
   assign tok_match = tok_valid_i && epc_reg[EPC_EN_BIT] && tok_i.addr == func_addr_i
                      && tok_i.ep == epc_reg[3:0]; // [RULE_13]

   // ************************************************************
   // Receive FIFO, warning and flush
   // ************************************************************
   assign rx_in_valid = rx_valid_i && rx_state_reg == RX_STORE;
   assign rx_pop      = bus_go && !wb_we_i && hit_rxd;
   assign rx_flush    = flush_pend_reg && rx_state_reg == RX_IDLE; // [RULE_04]
   assign rx_free     = 7'(RX_DEPTH) - rx_count;

   usbep_fifo #(
      .W     (DATA_W),
      .DEPTH (RX_DEPTH)
   ) u_rx_fifo (
      .mclk_i      (mclk_i),
      .rst_n_i     (rst_n_i),
      .flush_i     (rx_flush),
      .in_valid_i  (rx_in_valid),
      .in_ready_o  (rx_in_ready),
      .in_data_i   (rx_byte_i),
      .out_valid_o (rx_out_valid),
      .out_ready_i (rx_pop),
      .out_data_o  (rx_head),
      .count_o     (rx_count)
   );

   always_comb begin
      case (rxc_reg[6:5])
         2'b01:   warn_lim = WL_LIM1; // [RULE_01]
         2'b10:   warn_lim = WL_LIM2;
         2'b11:   warn_lim = WL_LIM3;
         default: warn_lim = '0;
      endcase
   end
   assign warn_hit = rx_free < warn_lim; // [RULE_02]

   // Event set wins over a write-one clear
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         warn_ev_reg <= 1'b0;
      end else if (warn_hit) begin
         warn_ev_reg <= 1'b1; // [RULE_02]
      end else if (wr_lo && hit_ev && wb_dat_i[EV_WARN_BIT]) begin
         warn_ev_reg <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flush_pend_reg <= 1'b0;
      end else if (wr_lo && hit_rxc && wb_dat_i[RXC_FLUSH_BIT]) begin
         flush_pend_reg <= 1'b1; // [RULE_03]
      end else if (rx_flush) begin
         flush_pend_reg <= 1'b0;
      end
   end

   // ************************************************************
   // Token and receive sequencing
   // ************************************************************
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rxc_reg        <= RXC_RST;
         rx_state_reg   <= RX_IDLE;
         setup_held_reg <= 1'b0;
         end_send_reg   <= 1'b0;
         end_setup_reg  <= 1'b0;
         end_kind_reg   <= HS_ACK;
         hs_valid_o     <= 1'b0;
         hs_kind_o      <= HS_ACK;
      end else begin
         hs_valid_o <= 1'b0;
         if (wr_lo && hit_rxc) begin
            rxc_reg <= wb_dat_i[7:0] & 8'h65; // [RULE_18]
         end
         case (rx_state_reg)
            RX_IDLE: begin
               if (rx_flush) begin
                  setup_held_reg <= 1'b0; // [RULE_03]
               end else if (tok_match && tok_i.pid == PID_SETUP) begin
                  if (rxc_reg[RXC_IGN_BIT]) begin
                     rx_state_reg <= RX_IDLE; // [RULE_05]
                  end else if (setup_held_reg) begin
                     rx_state_reg  <= RX_DROP; // [RULE_08]
                     end_send_reg  <= 1'b1;
                     end_setup_reg <= 1'b0;
                     end_kind_reg  <= HS_ACK;
                  end else if (flush_pend_reg || rx_out_valid) begin
                     rx_state_reg  <= RX_DROP; // [RULE_09]
                     end_send_reg  <= 1'b0;
                     end_setup_reg <= 1'b0;
                  end else begin
                     rx_state_reg  <= RX_STORE; // [RULE_07] [RULE_11]
                     end_send_reg  <= 1'b1;
                     end_setup_reg <= 1'b1;
                     end_kind_reg  <= HS_ACK;
                  end
               end else if (tok_match && tok_i.pid == PID_OUT) begin
                  setup_held_reg <= 1'b0;
                  end_setup_reg  <= 1'b0;
                  if (stall && rx_armed) begin
                     hs_valid_o         <= 1'b1; // [RULE_10]
                     hs_kind_o          <= HS_STALL;
                     rxc_reg[RXC_EN_BIT] <= 1'b0; // [RULE_06]
                  end else if (!rx_armed || !rx_in_ready || flush_pend_reg) begin
                     rx_state_reg <= RX_DROP;
                     end_send_reg <= !iso; // [RULE_12]
                     end_kind_reg <= HS_NAK;
                  end else begin
                     rx_state_reg <= RX_STORE;
                     end_send_reg <= !iso;
                     end_kind_reg <= HS_ACK;
                  end
               end else if (tok_match && tok_i.pid == PID_IN) begin
                  setup_held_reg <= 1'b0;
                  if (stall && mode_reg[MODE_TXEN_BIT]) begin
                     hs_valid_o <= 1'b1; // [RULE_10]
                     hs_kind_o  <= HS_STALL;
                  end else if (mode_reg[MODE_TXEN_BIT] && tx_out_valid) begin
                     hs_valid_o <= 1'b1;
                     hs_kind_o  <= HS_DATA;
                  end else if (!iso) begin
                     hs_valid_o <= 1'b1; // [RULE_12]
                     hs_kind_o  <= HS_NAK;
                  end
               end
            end
            RX_STORE, RX_DROP: begin
               if (rx_end_i) begin
                  rx_state_reg <= RX_IDLE;
                  hs_valid_o   <= end_send_reg;
                  hs_kind_o    <= end_kind_reg;
                  if (end_setup_reg) begin
                     setup_held_reg <= 1'b1; // [RULE_08]
                  end else if (rx_state_reg == RX_STORE) begin
                     rxc_reg[RXC_EN_BIT] <= 1'b0; // [RULE_06]
                  end
               end
            end
            default: rx_state_reg <= RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_busy_o <= 1'b0;
      end else begin
         rx_busy_o <= rx_state_reg != RX_IDLE;
      end
   end

   // ************************************************************
   // Transmit FIFO and byte stream
   // ************************************************************
   assign tx_in_valid = bus_req && wb_we_i && wb_sel_i[0] && hit_txd; // [RULE_15]
   assign tx_pop      = (tx_req_i && mode_reg[MODE_TXEN_BIT]) ||
                        (bus_go && !wb_we_i && hit_txd && mode_reg[MODE_TEST_BIT]);

   usbep_fifo #(
      .W     (DATA_W),
      .DEPTH (TX_DEPTH)
   ) u_tx_fifo (
      .mclk_i      (mclk_i),
      .rst_n_i     (rst_n_i),
      .flush_i     (1'b0),
      .in_valid_i  (tx_in_valid),
      .in_ready_o  (tx_in_ready),
      .in_data_i   (wb_dat_i[7:0]),
      .out_valid_o (tx_out_valid),
      .out_ready_i (tx_pop),
      .out_data_o  (tx_head),
      .count_o     ()
   );

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_valid_o <= 1'b0;
         tx_byte_o  <= '0;
      end else begin
         tx_valid_o <= tx_req_i && mode_reg[MODE_TXEN_BIT] && tx_out_valid;
         if (tx_req_i && tx_out_valid) begin
            tx_byte_o <= tx_head;
         end
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   a_ack_one_cycle: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
   a_warn_sets: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RULE_02]
      (rxc_reg[6:5] == 2'b11 && rx_free < WL_LIM3) |=> warn_ev_reg)
      else $error("warning flag not set");
   a_warn_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RULE_01]
      (rxc_reg[6:5] == 2'b00 && !warn_ev_reg) |=> !warn_ev_reg)
      else $error("warning flag set while disabled");
   a_flush_waits: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RULE_04]
      (rx_state_reg == RX_STORE) |-> !rx_flush) else $error("flush during reception");
   a_flush_empty: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RULE_03]
      rx_flush |=> rx_count == '0 && !flush_pend_reg) else $error("flush left data");
   a_setup_mask: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RULE_05]
      (tok_match && tok_i.pid == PID_SETUP && rxc_reg[RXC_IGN_BIT] && rx_state_reg == RX_IDLE
       && !rx_flush) |=> rx_state_reg == RX_IDLE) else $error("masked SETUP accepted");
   a_out_disarm: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RULE_06]
      (rx_state_reg == RX_STORE && rx_end_i && !end_setup_reg && !(wr_lo && hit_rxc))
      |=> !rx_armed) else $error("reception still armed after packet");
   a_stall_out: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RULE_10]
      (tok_match && tok_i.pid == PID_OUT && stall && rx_armed && rx_state_reg == RX_IDLE
       && !rx_flush) |=> hs_valid_o && hs_kind_o == HS_STALL) else $error("no STALL on OUT");
   a_no_stall_setup: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RULE_11]
      (tok_match && tok_i.pid == PID_SETUP && rx_state_reg == RX_IDLE) |=> !hs_valid_o)
      else $error("SETUP answered at token");
   a_iso_no_nak: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RULE_12]
      (hs_valid_o && hs_kind_o == HS_NAK) |-> !$past(iso)) else $error("NAK on iso endpoint");
   a_disabled_quiet: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RULE_13]
      (!epc_reg[EPC_EN_BIT] && rx_state_reg == RX_IDLE) |=> !hs_valid_o)
      else $error("disabled endpoint answered");
   a_setup_repeat: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // [RULE_08]
      (tok_match && tok_i.pid == PID_SETUP && setup_held_reg && !rxc_reg[RXC_IGN_BIT]
       && rx_state_reg == RX_IDLE && !rx_flush) |=> rx_state_reg == RX_DROP && end_send_reg)
      else $error("repeated SETUP not dropped with ACK");

   c_out_packet: cover property (@(posedge mclk_i) rx_state_reg == RX_STORE && rx_end_i);
   c_setup_drop: cover property (@(posedge mclk_i) rx_state_reg == RX_DROP && end_send_reg);
   c_in_data: cover property (@(posedge mclk_i) hs_valid_o && hs_kind_o == HS_DATA);
   c_flush: cover property (@(posedge mclk_i) rx_flush);

endmodule : usbep_ctrl

// [dv/usbep_host_model.sv]
// Purpose: Host side: sends tokens and payload bytes, counts handshakes
// Assumes: Device address 2a, endpoint 3
// Notes:   Byte line shows inverted last byte outside packets
`timescale 1ns/1ns
module usbep_host_model
   import usbep_pkg::*;
(
   input  wire logic               mclk_i,      // Clock
   input  wire logic               hs_valid_i,  // Handshake pulse
   output logic                    tok_valid_o, // Token strobe
   output usbep_pkg::usbep_tok_s   tok_o,       // Token
   output logic                    rx_valid_o,  // Byte strobe
   output logic [7:0]              rx_byte_o,   // Byte
   output logic                    rx_end_o     // Packet end
);
   int hs_cnt = 0;
   initial begin
      tok_valid_o = 1'b0;
      tok_o       = '0;
      rx_valid_o  = 1'b0;
      rx_byte_o   = 8'h00;
      rx_end_o    = 1'b0;
   end
   always @(posedge mclk_i) if (hs_valid_i) hs_cnt++;
   task automatic xfer(usbep_pid_e p, int n);
      @(posedge mclk_i);
      tok_valid_o <= 1'b1;
      tok_o       <= '{pid: p, addr: 7'h2a, ep: 4'h3};
      @(posedge mclk_i);
      tok_valid_o <= 1'b0;
      for (int i = 0; i < n; i++) begin
         @(posedge mclk_i);
         rx_valid_o <= 1'b1;
         rx_byte_o  <= 8'(i);
      end
      @(posedge mclk_i);
      rx_valid_o <= 1'b0;
      rx_byte_o  <= ~rx_byte_o;
      rx_end_o   <= (p != PID_IN);
      @(posedge mclk_i);
      rx_end_o   <= 1'b0;
   endtask : xfer
endmodule : usbep_host_model

// [dv/testbench.sv]
// Purpose: Bus and token scenarios for the endpoint control block
// Assumes: Host model drives the token side
// Notes:   Device address 2a, endpoint 3
`timescale 1ns/1ns
module testbench;
   import usbep_pkg::*;
   logic        clk = 0, rst_n = 0, cyc = 0, we = 0, tx_req = 0;
   logic [31:0] adr = '0, wdat = '0, rdat, q;
   logic        ack, hs_v, tx_v, tv, rv, re, busy;
   logic [7:0]  tx_b, rb;
   usbep_tok_s  tok;
   usbep_hs_e   hs_k;
   int          error_cnt = 0, num_checks = 0;
   initial forever #25 clk = ~clk;
   usbep_host_model host_u (.mclk_i(clk), .hs_valid_i(hs_v), .tok_valid_o(tv),
      .tok_o(tok), .rx_valid_o(rv), .rx_byte_o(rb), .rx_end_o(re));
   usbep_ctrl dut_u (.mclk_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .func_addr_i(7'h2a), .tok_valid_i(tv), .tok_i(tok),
      .rx_valid_i(rv), .rx_byte_i(rb), .rx_end_i(re), .hs_valid_o(hs_v),
      .hs_kind_o(hs_k), .tx_req_i(tx_req), .tx_valid_o(tx_v), .tx_byte_o(tx_b),
      .rx_busy_o(busy));
   // ****************************************
   // Tasks
   // ****************************************
   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done
   task automatic chk(string n, logic [31:0] e, logic [31:0] s);
      num_checks++;
      if (s !== e) begin
         $display("[ERR] %s exp %h got %h", n, e, s);
         error_cnt++;
      end
   endtask : chk
   task automatic wb(logic w, logic [31:0] i, logic [31:0] d);
      int k;
      @(posedge clk);
      cyc  <= 1'b1;
      we   <= w;
      adr  <= {i[29:0], 2'b00};
      wdat <= d;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 20);
      if (k >= 20) begin
         error_cnt++;
         test_done();
      end
      q = rdat;
      cyc <= 1'b0;
      @(posedge clk);
   endtask : wb
   task automatic rd(logic [31:0] i, logic [31:0] e);
      wb(1'b0, i, 32'h0);
      chk($sformatf("reg %h", i), e, q);
   endtask : rd
   task automatic hs(usbep_pid_e p, int n, int ex, usbep_hs_e k);
      int c;
      c = host_u.hs_cnt;
      host_u.xfer(p, n);
      repeat (3) @(posedge clk);
      chk("hs count", 32'(ex), 32'(host_u.hs_cnt - c));
      if (ex > 0) chk("hs kind", 32'(k), 32'(hs_k));
   endtask : hs
   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      rd(RXCTL_IDX, 32'h0);
      wb(1'b1, EPCFG_IDX, 32'hffff_ffff);
      rd(EPCFG_IDX, 32'hbf);
      wb(1'b1, RXCTL_IDX, 32'hff65);
      rd(RXCTL_IDX, 32'h65);
      wb(1'b1, EPCFG_IDX, 32'h93);
      wb(1'b1, RXCTL_IDX, 32'h01);
      hs(PID_OUT, 0, 1, HS_STALL);
      rd(RXCTL_IDX, 32'h0);
      hs(PID_SETUP, 0, 1, HS_ACK);
      hs(PID_SETUP, 0, 1, HS_ACK);
      wb(1'b1, RXCTL_IDX, 32'h04);
      hs(PID_SETUP, 0, 0, HS_ACK);
      wb(1'b1, EPCFG_IDX, 32'h03);
      wb(1'b1, RXCTL_IDX, 32'h01);
      hs(PID_OUT, 0, 0, HS_ACK);
      wb(1'b1, EPCFG_IDX, 32'h13);
      hs(PID_OUT, 2, 1, HS_ACK);
      rd(RXCTL_IDX, 32'h0);
      rd(RXDATA_IDX, 32'h0);
      rd(RXDATA_IDX, 32'h1);
      wb(1'b1, RXCTL_IDX, 32'h61);
      hs(PID_OUT, 48, 1, HS_ACK);
      rd(EVENT_IDX, 32'h1);
      wb(1'b1, MODE_IDX, 32'h1);
      wb(1'b1, TXDATA_IDX, 32'h5a);
      tx_req <= 1'b1;
      @(posedge clk);
      tx_req <= 1'b0;
      #1 chk("tx byte", 32'h15a, {23'h0, tx_v, tx_b});
      wb(1'b1, MODE_IDX, 32'h3);
      wb(1'b1, TXDATA_IDX, 32'ha5);
      rd(TXDATA_IDX, 32'ha5);
      rd(32'h5000_1890, 32'h0);
      wb(1'b1, EPCFG_IDX, 32'h14);
      hs(PID_IN, 0, 0, HS_ACK);
      wb(1'b1, EPCFG_IDX, 32'h13);
      hs(PID_IN, 0, 1, HS_NAK);
      wb(1'b1, EPCFG_IDX, 32'h33);
      hs(PID_IN, 0, 0, HS_ACK);
      hs(PID_SETUP, 0, 0, HS_ACK);
      wb(1'b1, RXCTL_IDX, 32'h68);
      wb(1'b1, EVENT_IDX, 32'h1);
      rd(EVENT_IDX, 32'h0);
      wb(1'b1, EPCFG_IDX, 32'h13);
      wb(1'b1, RXCTL_IDX, 32'h01);
      fork
         hs(PID_OUT, 8, 1, HS_ACK);
         begin
            wb(1'b1, RXCTL_IDX, 32'h09);
            rd(RXCTL_IDX, 32'h09);
            chk("rx busy", 32'h1, {31'h0, busy});
         end
      join
      chk("rx busy", 32'h0, {31'h0, busy});
      rd(RXCTL_IDX, 32'h0);
      test_done();
   end
endmodule : testbench
